// ---- hdl/quad_counter_pkg.sv ----
// Shared constants for the quadrature decoder and position counter.
// Assumes one system clock; every figure below but COUNT_W_BASIC, CLK_PERIOD_NS and MAX_CLK_MHZ is referenced by name.
package quad_counter_pkg;
	localparam int          BYTE_W        = 8;
	localparam int          POS_W         = 16;
	localparam int          COUNT_W_FULL  = 16;
	localparam int          COUNT_W_BASIC = 12;
	localparam int          FILTER_LEN    = 3;
	localparam logic        SEL_HIGH_BYTE = 1'b0;
	localparam logic        DIR_UP        = 1'b1;
	localparam int          CLK_PERIOD_NS = 10;
	localparam int          MAX_CLK_MHZ   = 14;
	localparam logic [15:0] POS_RESET     = 16'h0000;

	typedef enum logic {
		LATCH_TRACK = 1'b0,
		LATCH_HOLD  = 1'b1
	} latch_state_t;
endpackage

// ---- hdl/quadrature_decoder_counter.sv ----
// Quadrature decoder, up/down position counter, position latch and byte port.
// Assumes encoder and host inputs are synchronous to clk; the pad logic
// resolves the data port from port_data and port_data_oe.
//
// Overview of operation
// - Position counter is 12 or 16 bits.
// - Both channels pass a digital noise filter.
// - Latched position leaves through 8-bit tri-state port.
// - All logic runs from one clock.
// - Reset clears counter, latch and inhibit logic.
// - Port driven while output enable low, registered one clock late on both edges.
// - Inhibit logic samples enable and select each clock.
// - Byte select routes one latch byte out.
// - One count pulse per valid decoder transition.
// - Direction valid before each count or carry pulse.
// - Carry pulse on counter overflow or underflow.
// - Host reads one or two bytes per mode.
`timescale 1ns/1ps
`default_nettype none

// One channel of the input filter: the output only moves after the raw
// input has held the new level for FILTER_LEN samples in a row.
module glitch_filter #(
	parameter int LEN = 3
) (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic raw,
	output var  logic clean
);
	logic [LEN-1:0] hist_q;
	logic           hist_d;
	wire            all_high = &hist_q;
	wire            all_low  = ~|hist_q;

	assign hist_d = all_high ? 1'b1 : (all_low ? 1'b0 : clean);

	always_ff @(posedge clk) begin
		if (!nrst) begin
			hist_q <= '0;
			clean  <= 1'b0;
		end else begin
			hist_q <= {hist_q[LEN-2:0], raw};
			clean  <= hist_d;
		end
	end
endmodule // glitch_filter

module quadrature_decoder_counter
	import quad_counter_pkg::*;
#(
	parameter int COUNT_W    = COUNT_W_FULL,
	parameter int FILTER_CNT = FILTER_LEN
) (
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire logic              encoder_phase_a,
	input  wire logic              encoder_phase_b,
	input  wire logic              oe_n,
	input  wire logic              byte_sel,
	output var  logic [BYTE_W-1:0] port_data,
	output var  logic              port_data_oe,
	output var  logic              decoder_count_pulse,
	output var  logic              count_direction,
	output var  logic              wrap_carry_pulse
);
	// The clock here is far faster than the documented maximum, so the
	// filter depth in cycles is a parameter rather than a fixed time.
	localparam logic [COUNT_W-1:0] COUNT_MAX  = {COUNT_W{1'b1}};
	localparam logic [COUNT_W-1:0] COUNT_ZERO = '0;

	logic               filt_a;
	logic               filt_b;
	logic               prev_a_q;
	logic               prev_b_q;
	logic [COUNT_W-1:0] count_q;
	logic [COUNT_W-1:0] count_d;
	logic [POS_W-1:0]   latch_q;
	logic [POS_W-1:0]   latch_d;
	latch_state_t       state_q;
	latch_state_t       state_d;
	logic               dir_q;
	logic               step_pend_q;
	logic               wrap_pend_q;

	glitch_filter #(.LEN(FILTER_CNT)) u_filt_a (
		.clk   (clk),
		.nrst  (nrst),
		.raw   (encoder_phase_a),
		.clean (filt_a)
	);

	glitch_filter #(.LEN(FILTER_CNT)) u_filt_b (
		.clk   (clk),
		.nrst  (nrst),
		.raw   (encoder_phase_b),
		.clean (filt_b)
	);

	// Exactly one channel moved: a legal quadrature step. Both moving at
	// once is an illegal jump and is dropped rather than guessed at.
	wire chg_a      = filt_a ^ prev_a_q;
	wire chg_b      = filt_b ^ prev_b_q;
	wire step_valid = chg_a ^ chg_b;
	wire step_up    = filt_a ^ prev_b_q;
	wire at_wrap    = step_up ? (count_q == COUNT_MAX) : (count_q == COUNT_ZERO);

	assign count_d = step_valid ? (step_up ? count_q + 1'b1 : count_q - 1'b1)
	                            : count_q;

	// A read abandoned with the high byte selected leaves the latch frozen;
	// the host must end on the low byte before it sees fresh positions.
	// Inhibit: a read freezes the latch from the first cycle output enable
	// is seen low, and the latch tracks again once enable is high with the
	// low byte selected, which is where a two-byte read ends.
	wire read_active = !oe_n;
	wire read_done   = oe_n && (byte_sel != SEL_HIGH_BYTE);

	always_comb begin
		state_d = state_q;
		case (state_q)
			LATCH_TRACK: if (read_active) state_d = LATCH_HOLD;
			LATCH_HOLD:  if (read_done)   state_d = LATCH_TRACK;
			default:     state_d = LATCH_TRACK;
		endcase
	end

	// Zero extension keeps the high byte meaningful in the narrow variant.
	wire [POS_W-1:0] count_ext = POS_W'(count_q);
	assign latch_d = (state_d == LATCH_TRACK && state_q == LATCH_TRACK) ? count_ext
	                                                                    : latch_q;

	wire [BYTE_W-1:0] byte_out = (byte_sel == SEL_HIGH_BYTE) ? latch_q[POS_W-1:BYTE_W]
	                                                         : latch_q[BYTE_W-1:0];

	always_ff @(posedge clk) begin
		if (!nrst) begin
			prev_a_q <= 1'b0;
			prev_b_q <= 1'b0;
			count_q  <= COUNT_ZERO;
			state_q  <= LATCH_TRACK;
			latch_q  <= POS_RESET;
		end else begin
			prev_a_q <= filt_a;
			prev_b_q <= filt_b;
			count_q  <= count_d;
			state_q  <= state_d;
			latch_q  <= latch_d;
		end
	end

	// Direction leaves on the edge that takes the step and the pulses rise
	// one edge later, so direction is settled before each pulse's rise.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			dir_q               <= DIR_UP;
			step_pend_q         <= 1'b0;
			wrap_pend_q         <= 1'b0;
			decoder_count_pulse <= 1'b0;
			wrap_carry_pulse    <= 1'b0;
		end else begin
			if (step_valid) begin
				dir_q <= step_up;
			end
			step_pend_q         <= step_valid;
			wrap_pend_q         <= step_valid && at_wrap;
			decoder_count_pulse <= step_pend_q;
			wrap_carry_pulse    <= wrap_pend_q;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			count_direction <= DIR_UP;
			port_data       <= '0;
			port_data_oe    <= 1'b0;
		end else begin
			count_direction <= step_valid ? step_up : dir_q;
			port_data       <= byte_out;
			port_data_oe    <= read_active;
		end
	end

	// Checks on the logic above.
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	a_filter_settle: assert property (
		$changed(filt_a) |-> ($past(encoder_phase_a, 2) == filt_a)
			&& ($past(encoder_phase_a, 3) == filt_a)
			&& ($past(encoder_phase_a, 4) == filt_a))
		else $error("Filtered channel moved without a settled input.");

	a_count_step: assert property (
		$changed(count_q) |-> (count_q == COUNT_W'($past(count_q) + 1'b1))
			|| (count_q == COUNT_W'($past(count_q) - 1'b1)))
		else $error("Counter moved by more than one.");

	a_pulse_per_step: assert property (
		step_valid |-> ##2 decoder_count_pulse)
		else $error("Valid transition gave no count pulse.");

	a_dir_settled: assert property (
		$rose(decoder_count_pulse) || $rose(wrap_carry_pulse) |-> $stable(count_direction))
		else $error("Direction changed at a pulse edge.");

	a_wrap_value: assert property (
		wrap_carry_pulse |-> (count_direction == DIR_UP) ? ($past(count_q) == COUNT_ZERO)
			: ($past(count_q) == COUNT_MAX))
		else $error("Carry pulse without a wrap of the counter.");

	a_port_enable: assert property (
		port_data_oe == $past(!oe_n))
		else $error("Port enable does not follow output enable.");

	a_byte_route: assert property (
		port_data_oe |-> port_data == ($past(byte_sel) == SEL_HIGH_BYTE
			? $past(latch_q[POS_W-1:BYTE_W]) : $past(latch_q[BYTE_W-1:0])))
		else $error("Wrong latch byte on the port.");

	a_latch_hold: assert property (
		(state_q == LATCH_HOLD) ##1 (state_q == LATCH_HOLD) |-> $stable(latch_q))
		else $error("Latch changed while held for a read.");

	a_count_in_read: assert property (
		step_valid && (state_q == LATCH_HOLD) |=> $changed(count_q))
		else $error("Step lost while the latch was held.");

	a_reset_clear: assert property (disable iff (1'b0)
		!nrst |=> (count_q == COUNT_ZERO) && (latch_q == POS_RESET)
			&& (state_q == LATCH_TRACK) && !port_data_oe)
		else $error("Reset did not clear counter, latch and inhibit.");

	// The second channel has the same filter and the same hazard as A.
	a_filter_b_settle: assert property (
		$changed(filt_b) |-> ($past(encoder_phase_b, 2) == filt_b)
			&& ($past(encoder_phase_b, 3) == filt_b)
			&& ($past(encoder_phase_b, 4) == filt_b))
		else $error("Filtered channel B moved without a settled input.");

	a_filter_reset: assert property (disable iff (1'b0)
		!nrst |=> !filt_a && !filt_b)
		else $error("Filter outputs not cleared by reset.");

	// Direction is judged from the channel levels, not from the decoder
	// terms, so a swapped lead test in the decoder shows up here.
	a_gray_dir: assert property (
		step_valid |=> (count_q == COUNT_W'($past(count_q) + 1'b1))
			== $past((chg_a && (filt_a != filt_b)) || (chg_b && (filt_a == filt_b))))
		else $error("Counter moved against the channel lead.");

	a_illegal_drop: assert property (
		chg_a && chg_b |=> $stable(count_q))
		else $error("Double channel jump changed the counter.");

	a_count_idle: assert property (
		!step_valid |=> $stable(count_q))
		else $error("Counter moved without a step.");

	a_pulse_source: assert property (
		decoder_count_pulse |-> $past(step_valid, 2))
		else $error("Count pulse without a step.");

	a_dir_follows: assert property (
		step_valid |=> (count_direction == $past(step_up)))
		else $error("Direction output does not follow the step.");

	a_carry_on_wrap: assert property (
		step_valid && at_wrap |-> ##2 wrap_carry_pulse)
		else $error("Counter wrapped without a carry pulse.");

	a_carry_with_count: assert property (
		wrap_carry_pulse |-> decoder_count_pulse)
		else $error("Carry pulse without a count pulse.");

	a_hold_entry: assert property (
		(state_q == LATCH_TRACK) && !oe_n |=> (state_q == LATCH_HOLD))
		else $error("Read did not freeze the latch.");

	a_hold_release: assert property (
		(state_q == LATCH_HOLD) && read_done |=> (state_q == LATCH_TRACK))
		else $error("Finished read did not release the latch.");

	a_latch_track: assert property (
		(state_q == LATCH_TRACK) && (state_d == LATCH_TRACK) |=> (latch_q == $past(count_ext)))
		else $error("Latch did not follow the counter.");

	// In the narrow variant the bits above the counter must read as zero.
	a_narrow_zero: assert property (
		(latch_q >> COUNT_W) == POS_W'(0))
		else $error("Latch holds bits above the counter width.");

	a_reset_outputs: assert property (disable iff (1'b0)
		!nrst |=> !decoder_count_pulse && !wrap_carry_pulse
			&& (count_direction == DIR_UP) && (port_data == '0))
		else $error("Reset did not clear the outputs.");
endmodule // quadrature_decoder_counter

`default_nettype wire

// ---- sim/quad_encoder_model.sv ----
// Encoder model: steps a Gray-coded pair of channels one state per request.
// Assumes requests are one clock wide and spaced wider than the input filter.
`timescale 1ns/1ps
`default_nettype none
module quad_encoder_model (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic step_req,
	input  wire logic step_up,
	input  wire logic glitch,
	output var  logic phase_a,
	output var  logic phase_b
);
	logic [1:0] pos_q;
	logic       glitch_q;
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pos_q <= 2'h0;
			glitch_q <= 1'b0;
		end else begin
			if (step_req) pos_q <= step_up ? pos_q + 2'h1 : pos_q - 2'h1;
			glitch_q <= glitch;
		end
	end
	// Phase A leads B when stepping up; a glitch flips A for one clock only.
	assign phase_a = (pos_q[0] ^ pos_q[1]) ^ glitch_q;
	assign phase_b = pos_q[1];
endmodule // quad_encoder_model
`default_nettype wire

// ---- sim/quadrature_decoder_counter_tb.sv ----
// Self-checking bench: encoder model on the channels, host reads the port.
// Assumes the 16-bit counter and the default filter length.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module quadrature_decoder_counter_tb;
	import quad_counter_pkg::*;
	logic clk, nrst, oe_n, byte_sel, step_req, step_up, glitch, pa, pb;
	logic [BYTE_W-1:0] port_data;
	logic port_data_oe, cnt_pulse, dir, carry, dir_seen;
	int failures = 0, checks = 0, pulses = 0, wraps = 0, cycles = 0;
	logic [15:0] v;
	logic [7:0] b;
	quad_encoder_model u_enc (.clk(clk), .nrst(nrst), .step_req(step_req), .step_up(step_up),
		.glitch(glitch), .phase_a(pa), .phase_b(pb));
	quadrature_decoder_counter #(.COUNT_W(16), .FILTER_CNT(3)) u_dut (.clk(clk), .nrst(nrst),
		.encoder_phase_a(pa), .encoder_phase_b(pb), .oe_n(oe_n), .byte_sel(byte_sel),
		.port_data(port_data), .port_data_oe(port_data_oe), .decoder_count_pulse(cnt_pulse),
		.count_direction(dir), .wrap_carry_pulse(carry));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cnt_pulse === 1'b1) begin
			pulses++;
			dir_seen = dir;
		end
		if (carry === 1'b1) wraps++;
		if (cycles == 3000) begin
			failures++;
			conclude();
		end
	end
	task automatic conclude();
		$display("counts: checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic step(input logic up, input int n);
		repeat (n) begin
			step_req <= 1'b1;
			step_up <= up;
			@(posedge clk);
			step_req <= 1'b0;
			repeat (6) @(posedge clk);
		end
		repeat (4) @(posedge clk);
	endtask
	// Steps taken after output enable falls, before the high byte is read, prove the latch holds.
	task automatic read_pos(input int n_up, output logic [15:0] r);
		oe_n <= 1'b0;
		byte_sel <= SEL_HIGH_BYTE;
		repeat (2) @(posedge clk);
		step(1'b1, n_up);
		#1 `CHK(port_data_oe, 1'b1)
		r[15:8] = port_data;
		@(posedge clk);
		byte_sel <= 1'b1;
		repeat (2) @(posedge clk);
		#1 r[7:0] = port_data;
		@(posedge clk);
		oe_n <= 1'b1;
		repeat (2) @(posedge clk);
		#1 `CHK(port_data_oe, 1'b0)
		repeat (4) @(posedge clk);
	endtask
	// An 8-bit host reads the low byte alone and still releases the latch.
	task automatic read_low(output logic [7:0] r);
		byte_sel <= 1'b1;
		oe_n <= 1'b0;
		repeat (2) @(posedge clk);
		#1 r = port_data;
		@(posedge clk);
		oe_n <= 1'b1;
		repeat (4) @(posedge clk);
	endtask
	initial begin
		{nrst, step_req, step_up, glitch} = 4'h0;
		{oe_n, byte_sel} = 2'h3;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		#1 `CHK({port_data_oe, dir}, 2'h1)
		@(posedge clk);
		step(1'b1, 5);
		read_pos(0, v);
		`CHK(v, 16'h0005)
		`CHK({pulses, dir_seen}, {32'd5, DIR_UP})
		$display("test up count done");
		step(1'b0, 7);
		read_pos(0, v);
		`CHK(v, 16'hFFFE)
		`CHK(v[15:8], 8'hFF)
		`CHK({pulses, wraps, dir_seen}, {32'd12, 32'd1, 1'b0})
		$display("test down wrap done");
		read_pos(3, v);
		`CHK(v, 16'hFFFE)
		read_pos(0, v);
		`CHK(v, 16'h0001)
		`CHK({pulses, wraps}, {32'd15, 32'd2})
		$display("test held read done");
		glitch <= 1'b1;
		@(posedge clk);
		glitch <= 1'b0;
		repeat (10) @(posedge clk);
		read_pos(0, v);
		`CHK({v, pulses}, {16'h0001, 32'd15})
		$display("test glitch done");
		step(1'b1, 2);
		read_low(b);
		`CHK(b, 8'h03)
		read_pos(0, v);
		`CHK({v, pulses}, {16'h0003, 32'd17})
		$display("test low byte read done");
		conclude();
	end
endmodule // quadrature_decoder_counter_tb
`default_nettype wire
